// file: design/scr_pkg.sv
/*
 * Constants for the synchronous character receiver: register offsets on the
 * AHB-Lite slave, field positions, command codes, reset values, CRC polynomials.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
package scr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_INT_CTRL = 8'h04;
   localparam logic [7:0] OFS_RX_CTRL = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_TX_CTRL = 8'h10;
   localparam logic [7:0] OFS_SYNC_LOW = 8'h14;
   localparam logic [7:0] OFS_SYNC_HIGH = 8'h18;
   localparam logic [7:0] OFS_MISC = 8'h1C;
   localparam logic [7:0] OFS_LINE_STAT = 8'h20;
   localparam logic [7:0] OFS_RX_COND = 8'h24;
   localparam logic [7:0] OFS_RX_DATA = 8'h28;
   // Field positions
   localparam int CMD_CRC_LO = 6;
   localparam int CMD_ERR_LO = 3;
   localparam int ICR_PAR_IRQ = 2;
   localparam int RCR_LEN_LO = 6;
   localparam int RCR_HUNT = 4;
   localparam int RCR_STRIP = 1;
   localparam int RCR_CRC_EN = 0;
   localparam int MSR_SYNC_LO = 4;
   localparam int MSR_PAR_SENSE = 1;
   localparam int MSR_PAR_EN = 0;
   localparam int TCR_CRC16 = 2;
   localparam int MISC_PRESET = 7;
   localparam int MISC_SHORT = 0;
   localparam int LSR_AVAIL = 0;
   localparam int LSR_HUNT = 4;
   localparam int RCS_PAR = 4;
   localparam int RCS_OVR = 5;
   localparam int RCS_CRC = 6;
   // Error entry bit positions inside one error FIFO word
   localparam int ERR_PAR = 0;
   localparam int ERR_OVR = 1;
   localparam int ERR_CRC = 2;
   // Command and mode codes
   localparam logic [1:0] CMD_CRC_RESET = 2'h1;
   localparam logic [2:0] CMD_ERR_RESET = 3'h6;
   localparam logic [1:0] MODE_SYNC8 = 2'h0;
   localparam logic [1:0] MODE_SYNC16 = 2'h1;
   localparam logic [1:0] MODE_EXT = 2'h3;
   // Character framing
   localparam logic [3:0] MIN_CHAR_BITS = 4'h5;
   localparam logic [3:0] SNAP_BITS = 4'h8;
   localparam logic [3:0] WIDE_FRAME = 4'h9;
   // CRC polynomials and presets
   localparam logic [15:0] POLY_CCITT = 16'h1021;
   localparam logic [15:0] POLY_CRC16 = 16'h8005;
   localparam logic [15:0] CRC_ONES = 16'hFFFF;
   localparam logic [15:0] CRC_ZEROS = 16'h0000;
endpackage

// file: design/scr_top.sv
/*
 * Synchronous character receiver with AHB-Lite register slave.
 * Hunts for a 6/8/12/16-bit sync pattern or follows an external sync pin,
 * assembles 5..8-bit characters with optional parity, strips sync characters,
 * and checks CRC through an 8-bit delay stage. Receive clock, data and sync
 * pin come from outside and are resynchronised to core_clk, which must run at
 * least four times faster than the receive clock.
 */
// The AHB-Lite register port and the register offsets were decided locally.
// Operation
// R1: In hunt, shift each bit and compare with sync; on match start assembling.
// R2: Sync length from mode bits 5:4 and misc bit 0: 6, 8, 12 or 16 bits.
// R3: Mode bits 5:4 both one select external sync on the sync pin.
// R4: External sync: hunt status shows sync pin; host still enters hunt.
// R5: External sync: assembly starts at the receive edge before sync falls.
// R6: External sync: receiver leaves hunt as soon as sync pin goes low.
// R7: Otherwise sync pin is an output pulsed low on every pattern match.
// R8: Strip enabled: characters equal to low sync register are not loaded.
// R9: Stripped characters never enter the CRC calculation.
// R10: Host uses stripping only when character length equals sync length.
// R11: Receive control bit 4 written one enters hunt; zero does nothing.
// R12: Every change of the hunt status flag raises an event pulse.
// R13: Control bits 7:6 give 5..8 bits; data right-justified, later bits above.
// R14: Parity enable adds a bit checked even when sense is one, else odd.
// R15: With eight data bits the parity bit is not in the data buffer.
// R16: Parity error kept per entry, latched until error reset, gated interrupt.
// R17: Transmit control bit 2 picks CRC-16 when one, CCITT when zero.
// R18: Misc bit 7 presets the CRC checker to all ones, else all zeros.
// R19: CRC checker preset while hunting; command bits 7:6 also reset it.
// R20: CRC checked only while receive control bit 0 is one.
// R21: Host enables CRC only after first data character unless stripping.
// R22: 8-bit delay before CRC; enable change acts at next FIFO load.
// R23: CRC result flag stored with each character written to the FIFO.
// R24: Entering hunt disables and resets the CRC checker.
// R25: A character completing while the FIFO is full flags overrun there.
`timescale 1ns/1ps
module scr_top import scr_pkg::*; #(
   parameter int DEPTH = 3 // Receive FIFO depth
) (
   input wire logic core_clk, // 25 MHz system clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready, always high
   output logic hresp, // AHB response, always OKAY
   output logic [31:0] hrdata, // AHB read data
   input wire logic rx_clk, // Receive clock from remote transmitter
   input wire logic rx_data, // Serial receive data
   input wire logic sync_in_n, // Sync pin input level
   output logic sync_out_n, // Sync pin output level, low on match
   output logic sync_oe, // Sync pin output enable
   output logic ext_stat_evt, // One-cycle pulse on hunt flag change
   output logic spec_rx_irq // Special receive condition request
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic dph;
      logic dwr;
      logic [7:0] daddr;
      logic [31:0] rdat;
      logic rdy;
      logic [7:0] icr;
      logic [7:0] rcr;
      logic [7:0] msr;
      logic [7:0] tcr;
      logic [7:0] syl;
      logic [7:0] syh;
      logic [7:0] misc;
      logic rclk_s1;
      logic rclk_s2;
      logic rclk_d;
      logic rxd_s1;
      logic rxd_s2;
      logic syn_s1;
      logic syn_s2;
      logic hunt;
      logic flag_d;
      logic evt;
      logic [15:0] sr;
      logic [3:0] bcnt;
      logic pend;
      logic [3:0] pcnt;
      logic ppar;
      logic sync_n;
      logic oe;
      logic [15:0] crc;
      logic crc_on;
      logic [7:0] dly;
      logic [DEPTH-1:0][7:0] fd;
      logic [DEPTH-1:0][2:0] fe;
      logic [CW-1:0] cnt;
      logic par_lat;
      logic sirq;
   } scr_state_s;

   scr_state_s s;
   scr_state_s n;

   // Bytewise CRC over one character, first received bit first
   function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d, logic [15:0] p);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[15] ^ d[i];
         r = {r[14:0], 1'b0};
         if (fb) begin
            r = r ^ p;
         end
      end
      return r;
   endfunction

   // R2 sync length compare; newest bit sits at the top of the shift register
   function automatic logic sync_match(logic [15:0] v, logic [1:0] m, logic sh,
                                       logic [7:0] hi, logic [7:0] lo);
      logic r;
      r = 1'b0;
      if (m == MODE_SYNC8) begin
         r = sh ? (v[15:10] == hi[7:2]) : (v[15:8] == hi);
      end else if (m == MODE_SYNC16) begin
         r = sh ? (v[15:4] == {hi, lo[7:4]}) : (v == {hi, lo});
      end
      return r;
   endfunction

   // Parity over the last tot bits; sense one means even
   function automatic logic par_bad(logic [15:0] v, logic [3:0] tot, logic sense);
      logic [15:0] w;
      w = v >> (5'h10 - {1'b0, tot});
      return sense ? (^w) : ~(^w);
   endfunction

   logic bit_edge;
   logic [15:0] sr_n;
   logic ext;
   logic [3:0] total;
   logic [3:0] wpt;
   logic match;
   logic asm_bit;
   logic [3:0] cnt_n;
   logic done;
   logic [3:0] pc_n;
   logic do_wr;
   logic [7:0] wdata;
   logic wpar;
   logic drop;
   logic addr_ph;
   logic pop;
   logic flag_rep;
   logic [15:0] poly;
   logic [15:0] preset;

   // Receive datapath decode, shared by the state update and the checks
   assign bit_edge = s.rclk_s2 & ~s.rclk_d;
   assign sr_n = {s.rxd_s2, s.sr[15:1]};
   assign ext = (s.msr[MSR_SYNC_LO+:2] == MODE_EXT);
   assign total = MIN_CHAR_BITS + {2'h0, s.rcr[RCR_LEN_LO+:2]} + {3'h0, s.msr[MSR_PAR_EN]};
   assign wpt = (total > SNAP_BITS) ? total : SNAP_BITS;
   assign match = sync_match(sr_n, s.msr[MSR_SYNC_LO+:2], s.misc[MISC_SHORT], s.syh, s.syl);
   assign asm_bit = bit_edge & ~s.hunt;
   assign cnt_n = s.bcnt + 4'h1;
   assign done = asm_bit & (cnt_n == total);
   assign pc_n = done ? total : s.pcnt + 4'h1;
   // R13 snapshot waits until eight bits from the character start are in, or all nine of a nine-bit frame
   assign do_wr = asm_bit & (done | s.pend) & (pc_n == wpt);
   // R15 nine-bit frame drops the parity bit from the data
   assign wdata = (total == WIDE_FRAME) ? sr_n[14:7] : sr_n[15:8];
   // R14 parity checked at character end, held until the snapshot
   assign wpar = done ? (s.msr[MSR_PAR_EN] & par_bad(sr_n, total, s.msr[MSR_PAR_SENSE])) : s.ppar;
   // R8 strip compare across all eight bits
   assign drop = s.rcr[RCR_STRIP] & (wdata == s.syl);
   assign addr_ph = hsel & htrans[1] & hready;
   assign pop = addr_ph & ~hwrite & (haddr[7:0] == OFS_RX_DATA) & (s.cnt != '0);
   // R4 status flag follows the pin in external sync mode
   assign flag_rep = ext ? s.syn_s2 : s.hunt;
   // R17 polynomial select
   assign poly = s.tcr[TCR_CRC16] ? POLY_CRC16 : POLY_CCITT;
   // R18 preset value
   assign preset = s.misc[MISC_PRESET] ? CRC_ONES : CRC_ZEROS;

   // Next-state logic for the whole block
   always_comb begin
      logic [15:0] c;
      logic [7:0] wd;
      c = '0;
      wd = '0;
      n = s;
      n.rdy = 1'b1;
      n.evt = 1'b0;
      // Two-stage synchronisers; only the second stage is read
      n.rclk_s1 = rx_clk;
      n.rclk_s2 = s.rclk_s1;
      n.rclk_d = s.rclk_s2;
      n.rxd_s1 = rx_data;
      n.rxd_s2 = s.rxd_s1;
      n.syn_s1 = sync_in_n;
      n.syn_s2 = s.syn_s1;
      // R3 pin is only driven outside external sync mode
      n.oe = ~ext;
      // Address phase: capture and prepare read data so hrdata leaves a flop
      n.dph = addr_ph;
      n.dwr = hwrite;
      n.daddr = haddr[7:0];
      if (addr_ph & ~hwrite) begin
         unique case (haddr[7:0])
            OFS_INT_CTRL: n.rdat = {24'h0, s.icr};
            OFS_RX_CTRL: n.rdat = {24'h0, s.rcr};
            OFS_MODE: n.rdat = {24'h0, s.msr};
            OFS_TX_CTRL: n.rdat = {24'h0, s.tcr};
            OFS_SYNC_LOW: n.rdat = {24'h0, s.syl};
            OFS_SYNC_HIGH: n.rdat = {24'h0, s.syh};
            OFS_MISC: n.rdat = {24'h0, s.misc};
            OFS_LINE_STAT: begin
               n.rdat = '0;
               n.rdat[LSR_AVAIL] = (s.cnt != '0);
               n.rdat[LSR_HUNT] = flag_rep;
            end
            OFS_RX_COND: begin
               n.rdat = '0;
               n.rdat[RCS_PAR] = s.fe[0][ERR_PAR] | s.par_lat;
               n.rdat[RCS_OVR] = s.fe[0][ERR_OVR];
               n.rdat[RCS_CRC] = s.fe[0][ERR_CRC];
            end
            OFS_RX_DATA: n.rdat = {24'h0, s.fd[0]};
            default: n.rdat = '0;
         endcase
      end
      // Pop the head entry; entries shift toward index zero
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            n.fd[i] = s.fd[i+1];
            n.fe[i] = s.fe[i+1];
         end
         n.fd[DEPTH-1] = '0;
         n.fe[DEPTH-1] = '0;
         n.cnt = s.cnt - CW'(1);
      end
      // Data phase writes
      if (s.dph & s.dwr) begin
         unique case (s.daddr)
            OFS_COMMAND: begin
               // R19 reset-checker command
               if (hwdata[CMD_CRC_LO+:2] == CMD_CRC_RESET) begin
                  n.crc = preset;
               end
               if (hwdata[CMD_ERR_LO+:3] == CMD_ERR_RESET) begin
                  n.par_lat = 1'b0;
               end
            end
            OFS_INT_CTRL: n.icr = hwdata[7:0];
            OFS_RX_CTRL: begin
               n.rcr = hwdata[7:0];
               n.rcr[RCR_HUNT] = 1'b0;
               // R11 one-shot enter-hunt command
               if (hwdata[RCR_HUNT]) begin
                  n.hunt = 1'b1;
               end
            end
            OFS_MODE: n.msr = hwdata[7:0];
            OFS_TX_CTRL: n.tcr = hwdata[7:0];
            OFS_SYNC_LOW: n.syl = hwdata[7:0];
            OFS_SYNC_HIGH: n.syh = hwdata[7:0];
            OFS_MISC: n.misc = hwdata[7:0];
            default: ;
         endcase
      end
      // Per-bit work on each rising receive clock edge
      if (bit_edge) begin
         n.sr = sr_n;
         // R7 match pulses the pin low for one bit time, boundary or not
         n.sync_n = ext | ~match;
         if (s.hunt) begin
            // R1 hunt compares after every shifted bit
            if (~ext & match) begin
               n.hunt = 1'b0;
               n.bcnt = '0;
               n.pend = 1'b0;
            end
         end else begin
            n.bcnt = done ? 4'h0 : cnt_n;
            n.pcnt = pc_n;
            n.ppar = wpar;
            n.pend = (done | s.pend) & ~do_wr;
         end
      end
      // R6 external sync ends hunt when the pin falls
      if (s.hunt & ext & ~s.syn_s2) begin
         n.hunt = 1'b0;
         // R5 bit taken at the preceding receive edge is the first one
         n.bcnt = 4'h1;
         n.pend = 1'b0;
      end
      // R9 character load; a stripped one skips FIFO, delay stage and checker
      if (do_wr & ~drop) begin
         // R22 delayed character enters CRC with the enable taken last load
         c = s.crc_on ? crc_byte(n.crc, s.dly, poly) : n.crc;
         n.crc = c;
         // R20 enable sampled only at a character load
         n.crc_on = s.rcr[RCR_CRC_EN];
         n.dly = wdata;
         wd = wdata;
         if (n.cnt == CW'(DEPTH)) begin
            // R25 full FIFO: newest entry overwritten and marked overrun
            n.fd[DEPTH-1] = wd;
            n.fe[DEPTH-1] = {(c != '0), 1'b1, wpar};
         end else begin
            // R23 CRC flag stored alongside the data
            n.fd[n.cnt] = wd;
            n.fe[n.cnt] = {(c != '0), 1'b0, wpar};
            n.cnt = n.cnt + CW'(1);
         end
         // R16 parity error latched; set wins over error reset
         if (wpar) begin
            n.par_lat = 1'b1;
         end
      end
      // R19 R24 hunting holds the checker preset and disabled
      if (n.hunt) begin
         n.crc = preset;
         n.crc_on = 1'b0;
      end
      // R12 any change of the reported flag makes an event
      n.flag_d = flag_rep;
      n.evt = (flag_rep != s.flag_d);
      // R16 interrupt gated by interrupt control bit 2
      n.sirq = s.icr[ICR_PAR_IRQ] & s.par_lat;
   end

   // State register; pins idle high and the receiver starts out hunting
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.rdy <= 1'b1;
         s.syn_s1 <= 1'b1;
         s.syn_s2 <= 1'b1;
         s.hunt <= 1'b1;
         s.flag_d <= 1'b1;
         s.sync_n <= 1'b1;
         s.oe <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register; hresp tied low (OKAY)
   assign hreadyout = s.rdy;
   assign hresp = 1'b0;
   assign hrdata = s.rdat;
   assign sync_out_n = s.sync_n;
   assign sync_oe = s.oe;
   assign ext_stat_evt = s.evt;
   assign spec_rx_irq = s.sirq;

   // R11 enter-hunt write takes effect at once
   hunt_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
      s.dph && s.dwr && s.daddr == OFS_RX_CTRL && hwdata[RCR_HUNT] |=> s.hunt)
      else $error("enter hunt command ignored");
   // R24 hunting keeps the checker off and preset
   hunt_crc_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
      s.hunt && $stable(s.misc) |-> !s.crc_on && s.crc == preset)
      else $error("checker active during hunt");
   // R7 a match drives the pin low next cycle
   sync_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
      bit_edge && !ext && match |=> !sync_out_n && sync_oe)
      else $error("sync pulse missing");
   // R6 external sync leaves hunt on a low pin
   ext_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
      s.hunt && ext && !s.syn_s2 |=> !s.hunt)
      else $error("hunt not left on sync pin");
   // R12 flag change gives an event pulse in the next cycle
   flag_event_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      flag_rep != s.flag_d |=> ext_stat_evt)
      else $error("hunt flag change without event");
   // R12 no event pulse while the flag stands still
   flag_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
      flag_rep == s.flag_d |=> !ext_stat_evt)
      else $error("event without hunt flag change");
   // R8 a stripped character leaves the FIFO count alone
   strip_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      do_wr && drop && !pop && !s.hunt |=> s.cnt == $past(s.cnt) && $stable(s.crc))
      else $error("stripped character loaded");
   // R25 load into a full FIFO marks overrun
   overrun_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
      do_wr && !drop && !pop && s.cnt == CW'(DEPTH) |=> s.fe[DEPTH-1][ERR_OVR])
      else $error("overrun not flagged");
   // R16 parity error latches and then asks for service
   parity_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
      do_wr && !drop && wpar && s.icr[ICR_PAR_IRQ] |=> s.par_lat ##1 spec_rx_irq)
      else $error("parity error not latched");
   // R3 pin released in external sync mode
   ext_release_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
      ext |=> !sync_oe)
      else $error("sync pin driven in external mode");
endmodule // scr_top

// file: dv/scr_far.sv
/* Far-side model: remote sync transmitter and external aligner.
   Assumes the receiver samples rx_data on the rise of rx_clk. */
`timescale 1ns/1ps
module scr_far (
   output logic rx_clk, // Stands low between calls
   output logic rx_data, // First bit first
   output logic sync_n // Low while aligned
);
   // Idle line, strobe high
   initial begin
      rx_clk = 1'h0;
      rx_data = 1'h0;
      sync_n = 1'h1;
   end
   // Data moves while the clock is low, 320 ns a bit
   task automatic send(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         rx_data = v[i];
         #160 rx_clk = 1'h1;
         #160 rx_clk = 1'h0;
      end
      rx_data = ~rx_data; // A stale bit must not pass for data
   endtask
   task automatic align(input logic [7:0] ch);
      send({15'h0000, ~ch[0]}, 1);
      send({15'h0000, ch[0]}, 1);
      sync_n = 1'h0;
      send({9'h000, ch[7:1]}, 7);
   endtask
   // Strobe back to idle once the bench has looked
   task automatic unalign();
      sync_n = 1'h1;
   endtask
endmodule // scr_far

// file: dv/testbench.sv
/* Self-checking bench: AHB-Lite tasks and call sequences with expected values.
   Assumes scr_top with a one-cycle bus answer and the scr_far model. */
`timescale 1ns/1ps
module testbench import scr_pkg::*; ;
   localparam logic [7:0] SH = 8'h96;
   localparam logic [7:0] SL = 8'h3A;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, v;
   logic hreadyout, hresp, sync_out_n, sync_oe, ext_stat_evt, spec_rx_irq;
   logic rx_clk, rx_data, far_sync_n, sync_pin;
   logic [15:0] poly, c1, c2;
   logic [7:0] th, tl;
   logic [7:0] ovd [3] = '{8'h11, 8'h22, 8'h44};
   int n_tab [4] = '{6, 8, 12, 16};
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int evt_n = 0;
   int pulse_n = 0;
   int e0, p0;
   always #20 core_clk = ~core_clk;
   // The block owns the sync pin unless it has let go of it
   assign sync_pin = sync_oe ? sync_out_n : far_sync_n;
   scr_top #(.DEPTH(3)) scr_top_i (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rx_clk(rx_clk), .rx_data(rx_data), .sync_in_n(sync_pin), .sync_out_n(sync_out_n),
      .sync_oe(sync_oe), .ext_stat_evt(ext_stat_evt), .spec_rx_irq(spec_rx_irq));
   scr_far scr_far_i (.rx_clk(rx_clk), .rx_data(rx_data), .sync_n(far_sync_n));
   // Event counting and the hang limit
   always @(posedge core_clk) begin
      cyc++;
      if (ext_stat_evt === 1'h1)
         evt_n++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   always @(negedge sync_out_n) pulse_n++;
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One single transfer; each phase is held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'h1) @(posedge core_clk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'h1) @(posedge core_clk);
      v = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'h1, a, {24'h0, d});
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e,
                         input logic [7:0] m);
      bus(1'h0, a, 32'h0);
      check(what, v & {24'hFFFFFF, m}, {24'h0, e});
   endtask
   // Polls until a character is waiting, bounded
   task automatic wait_char();
      for (int k = 0; k < 30; k++) begin
         bus(1'h0, OFS_LINE_STAT, 32'h0);
         if (v[LSR_AVAIL] === 1'h1)
            break;
      end
   endtask
   task automatic entry(input logic f, input logic [7:0] d);
      wait_char();
      rd_chk("crc flag", OFS_RX_COND, {1'h0, f, 6'h00}, 8'h40);
      rd_chk("entry data", OFS_RX_DATA, d, 8'hFF);
   endtask
   task automatic frame(input logic [7:0] ctrl, input logic [15:0] bits, input int n);
      wr(OFS_RX_CTRL, ctrl);
      scr_far_i.send({8'h00, SH}, 8);
      scr_far_i.send(bits, n);
   endtask
   // Bench's own CRC: MSB shift, data bit 0 first
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d,
                                        input logic [15:0] p);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[15] ^ d[i]) ? ((r << 1) ^ p) : (r << 1);
      return r;
   endfunction
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'h1;
      rd_chk("reset status", OFS_LINE_STAT, 8'h10, 8'h11); // hunt at reset
      check("sync oe", {31'h0, sync_oe}, 32'h1); // pin driven
      wr(OFS_SYNC_HIGH, SH);
      wr(OFS_SYNC_LOW, SL);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_MODE, (i > 1) ? 8'h10 : 8'h00);
         wr(OFS_MISC, {7'h00, ~i[0]});
         wr(OFS_RX_CTRL, 8'hD0);
         rd_chk("hunt set", OFS_LINE_STAT, 8'h10, 8'h10); // hunt entered
         e0 = evt_n;
         p0 = pulse_n;
         scr_far_i.send({SH, SL} >> (16 - n_tab[i]), n_tab[i]);
         scr_far_i.send({8'h00, 8'h41 + i[7:0]}, 8);
         wait_char();
         check("hunt left", {31'h0, v[LSR_HUNT]}, 32'h0); // match found
         check("hunt event", evt_n - e0, 32'h1); // flag fell
         check("sync pulse", {31'h0, pulse_n != p0}, 32'h1); // strobe seen
         rd_chk("sync data", OFS_RX_DATA, 8'h41 + i[7:0], 8'hFF); // length
      end
      wr(OFS_RX_CTRL, 8'hC0);
      rd_chk("hunt kept off", OFS_LINE_STAT, 8'h00, 8'h10); // zero ignored
      e0 = evt_n;
      wr(OFS_RX_CTRL, 8'hD0);
      rd_chk("rx control", OFS_RX_CTRL, 8'hC0, 8'hFF); // reads zero
      check("bus resp", {31'h0, hresp}, 32'h0); // command accepted
      check("entry event", evt_n - e0, 32'h1); // flag rose
      wr(OFS_MODE, 8'h00);
      wr(OFS_MISC, 8'h00);
      for (int n = 0; n < 3; n++) begin
         frame({n[1:0], 6'h10}, 16'h00E6, 8);
         wait_char();
         rd_chk("short char", OFS_RX_DATA, 8'hE6, 8'hFF); // snapshot
      end
      wr(OFS_INT_CTRL, 8'h04);
      wr(OFS_MODE, 8'h03);
      frame(8'hD0, 16'h015B, 9);
      wait_char();
      rd_chk("parity even", OFS_RX_COND, 8'h00, 8'h10); // even sense
      check("irq quiet", {31'h0, spec_rx_irq}, 32'h0); // no error
      rd_chk("ninth bit", OFS_RX_DATA, 8'h5B, 8'hFF); // parity hidden
      wr(OFS_MODE, 8'h01);
      frame(8'hD0, 16'h015B, 9);
      wait_char();
      rd_chk("parity odd", OFS_RX_COND, 8'h10, 8'h10); // odd sense
      check("irq raised", {31'h0, spec_rx_irq}, 32'h1); // error seen
      rd_chk("ninth bit", OFS_RX_DATA, 8'h5B, 8'hFF); // parity hidden
      wr(OFS_INT_CTRL, 8'h00);
      rd_chk("parity latch", OFS_RX_COND, 8'h10, 8'h10); // held
      check("irq masked", {31'h0, spec_rx_irq}, 32'h0); // gated
      wr(OFS_COMMAND, 8'h30);
      rd_chk("error reset", OFS_RX_COND, 8'h00, 8'h10); // cleared
      wr(OFS_MODE, 8'h00);
      frame(8'hD2, {8'h3C, SL}, 16); // equal lengths
      scr_far_i.send({8'h77, SL}, 16);
      wait_char();
      rd_chk("strip", OFS_RX_DATA, 8'h3C, 8'hFF); // sync dropped
      rd_chk("strip", OFS_RX_DATA, 8'h77, 8'hFF); // embedded dropped
      rd_chk("strip empty", OFS_LINE_STAT, 8'h00, 8'h01); // nothing more
      frame(8'hD0, 16'h2211, 16);
      scr_far_i.send(16'h4433, 16);
      for (int k = 0; k < 3; k++) begin
         rd_chk("overrun", OFS_RX_COND, {2'h0, k == 2, 5'h00}, 8'h20); // newest
         rd_chk("overrun data", OFS_RX_DATA, ovd[k], 8'hFF); // overwritten
      end
      for (int p = 0; p < 2; p++) begin
         poly = p[0] ? POLY_CRC16 : POLY_CCITT;
         c1 = crc8(16'h0000, 8'hA5, poly);
         for (int b = 0; b < 8; b++) begin
            th[b] = c1[15 - b];
            tl[b] = c1[7 - b];
         end
         c2 = crc8(c1, th, poly);
         wr(OFS_TX_CTRL, {5'h00, p[0], 2'h0});
         frame(8'hD0, 16'h0000, 8);
         wait_char();
         wr(OFS_RX_CTRL, 8'hC1); // after first char
         scr_far_i.send({th, 8'hA5}, 16);
         entry(1'h0, 8'h00); // disabled at load
         entry(1'h0, 8'hA5); // delay stage
         entry(c1 != 16'h0, th); // flag per entry
         scr_far_i.send({8'h5E, tl}, 16);
         entry(c2 != 16'h0, tl); // flag per entry
         entry(crc8(c2, tl, poly) != 16'h0, 8'h5E); // polynomial
      end
      wr(OFS_MISC, 8'h80);
      frame(8'hD0, 16'h0000, 8);
      entry(1'h1, 8'h00); // preset ones
      wr(OFS_MISC, 8'h00);
      wr(OFS_COMMAND, 8'h40);
      scr_far_i.send(16'h0000, 8);
      entry(1'h0, 8'h00); // reset command
      wr(OFS_MODE, 8'h30);
      wr(OFS_RX_CTRL, 8'hD0);
      rd_chk("pin hunt", OFS_LINE_STAT, 8'h10, 8'h11); // pin level
      check("pin input", {31'h0, sync_oe}, 32'h0); // pin released
      scr_far_i.send(16'h00F0, 8);
      scr_far_i.align(8'hC3);
      wait_char();
      check("hunt left", {31'h0, v[LSR_HUNT]}, 32'h0); // strobe low
      rd_chk("aligned", OFS_RX_DATA, 8'hC3, 8'hFF); // first bit
      scr_far_i.unalign();
      give_verdict();
   end
endmodule // testbench
